// *** cfs_pkg.sv ***
// constants, field layouts and state types of the converter fault supervisor
package cfs_pkg;

  localparam int MV_W  = 12;
  localparam int TMP_W = 8;
  localparam int PRD_W = 20;
  localparam int NFLT  = 5;

  // register offsets
  localparam logic [7:0] OFS_POLICY = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h01;
  localparam logic [7:0] OFS_CURLIM = 8'h02;
  localparam logic [7:0] OFS_PGDLY  = 8'h03;
  localparam logic [7:0] OFS_SDMODE = 8'h04;
  localparam logic [7:0] OFS_HEALTH = 8'h05;

  // reset values
  localparam logic [7:0] POLICY_RST = 8'h43;
  localparam logic [5:0] THRESH_RST = 6'h08;
  localparam logic [7:0] CURLIM_RST = 8'h80;
  localparam logic [7:0] PGDLY_RST  = 8'h00;
  localparam logic [2:0] SDMODE_RST = 3'h0;
  localparam logic [6:0] HEALTH_RST = 7'h7F;

  // field positions
  localparam int THR_UPPER_BIT  = 5;
  localparam int THR_LOWER_BIT  = 4;
  localparam int THR_HIGH_LSB   = 2;
  localparam int THR_LOW_LSB    = 0;
  localparam int POL_TRACK_EN   = 7;
  localparam int POL_LATCH_BASE = 1;
  localparam int CURLIM_TCOMP   = 7;
  localparam int SD_UV_CRIT     = 0;
  localparam int SD_OT_CRIT     = 1;
  localparam int SD_PG_IMMED    = 2;

  // health flag bits, one means healthy
  localparam int HF_OV = 0;
  localparam int HF_UV = 1;
  localparam int HF_OC = 2;
  localparam int HF_OT = 3;
  localparam int HF_TR = 4;
  localparam int HF_PT = 5;
  localparam int HF_PG = 6;

  // percentages of setpoint
  localparam logic [7:0] PCT_BASE   = 8'd100;
  localparam logic [7:0] PG_HI_NAR  = 8'd105;
  localparam logic [7:0] PG_HI_WIDE = 8'd110;
  localparam logic [7:0] PG_LO_NAR  = 8'd95;
  localparam logic [7:0] PG_LO_WIDE = 8'd90;
  localparam logic [7:0] OV_PCT_0   = 8'd110;
  localparam logic [7:0] OV_PCT_1   = 8'd120;
  localparam logic [7:0] OV_PCT_2   = 8'd130;
  localparam logic [7:0] UV_PCT_0   = 8'd75;
  localparam logic [7:0] UV_PCT_1   = 8'd80;
  localparam logic [7:0] UV_PCT_2   = 8'd85;
  localparam logic [7:0] UV_PCT_3   = 8'd90;

  // temperatures in degC, voltages in mV
  localparam logic [TMP_W-1:0] TEMP_WARN_SET = 8'd120;
  localparam logic [TMP_W-1:0] TEMP_WARN_CLR = 8'd117;
  localparam logic [TMP_W-1:0] TEMP_TRIP     = 8'd120;
  localparam logic [TMP_W-1:0] TEMP_RESTART  = 8'd110;
  localparam logic [MV_W-1:0]  TRACK_TOL_MV  = 12'd250;

  // timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned CYC_PER_MS_DFLT = CLK_HZ / 1000;
  localparam logic [7:0]  RETRY_MS        = 8'd130;
  localparam logic [7:0]  PG_DELAY_MAX_MS = 8'd150;

  typedef struct packed {
    logic [MV_W-1:0]  vout;     // measured output
    logic [MV_W-1:0]  setp;     // present setpoint incl. margining
    logic [MV_W-1:0]  target;   // programmed ramp value
    logic [MV_W-1:0]  prebias;  // pre-bias level
    logic [TMP_W-1:0] temp;     // controller temperature
    logic             oc_hit;   // current comparator
    logic             run;      // run control bit
    logic             ramp_up;
    logic             steady;
    logic             ramp_dn;
    logic             margin;   // margining transition
    logic             pg_in;    // level on window pin
  } cfs_meas_t;

  typedef struct packed {
    logic fast_off;    // both switches off
    logic ov_clamp;    // high side off, low side on
    logic seq_off;     // sequenced turn-off
    logic crit_off;    // critical turn-off
    logic restart_ok;  // no fault holds the converter off
  } cfs_shut_t;

  typedef struct packed {
    cfs_meas_t  m;
    logic [7:0] policy;
    logic [5:0] thr;
    logic [7:0] curlim;
    logic [7:0] pgdly;
    logic [2:0] sdmode;
    logic [6:0] flags;
    logic [15:0] ms_cnt;
    logic [7:0] retry_ms;
    logic       retry_seen;
    logic [7:0] pg_ms;
    logic       pg_armed;
    logic       pg_low;
    logic       run_q;
    logic [7:0] rd_data;
    cfs_shut_t  shut;
  } cfs_state_t;

  function automatic logic [7:0] cfs_ov_pct(input logic [1:0] sel);
    unique case (sel)
      2'b00:   return OV_PCT_0;
      2'b01:   return OV_PCT_1;
      default: return OV_PCT_2;
    endcase
  endfunction : cfs_ov_pct

  function automatic logic [7:0] cfs_uv_pct(input logic [1:0] sel);
    unique case (sel)
      2'b00: return UV_PCT_0;
      2'b01: return UV_PCT_1;
      2'b10: return UV_PCT_2;
      2'b11: return UV_PCT_3;
    endcase
  endfunction : cfs_uv_pct

  function automatic logic [PRD_W-1:0] cfs_scale(input logic [MV_W-1:0] v,
                                                 input logic [7:0] pct);
    return PRD_W'(v) * PRD_W'(pct);
  endfunction : cfs_scale

endpackage : cfs_pkg

// *** cfs_top.sv ***
// converter fault supervisor: limits, fault flags, window pin and register port
module cfs_top
  import cfs_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DFLT
) (
  input  wire logic       clk,          // controller clock, 20 MHz
  input  wire logic       sys_rst,      // async reset, active high
  input  wire cfs_meas_t  meas_in,      // sensing and sequencer status
  input  wire logic       reg_wr,       // register write strobe
  input  wire logic [7:0] reg_addr,     // register address
  input  wire logic [7:0] reg_wdata,    // register write data
  output logic      [7:0] reg_rd_data,  // read data for reg_addr, one cycle late
  output cfs_shut_t       shut,         // switch shutdown requests
  output logic            pg_out,       // window pin drive level, always low
  output logic            pg_oe,        // window pin pull-down enable
  output logic            oc_tcomp_en,  // current threshold temp compensation
  output logic      [6:0] health_flags  // status flags, zero marks a problem
);

  cfs_state_t s;
  cfs_state_t next_s;

  logic [NFLT-1:0]  cond;
  logic [NFLT-1:0]  rel;
  logic [NFLT-1:0]  hclr;
  logic [PRD_W-1:0] v100;
  logic [MV_W-1:0]  trk_diff;
  logic [7:0]       pg_hi;
  logic [7:0]       pg_lo;
  logic [7:0]       dly_ms;
  logic             above_pb;
  logic             tick;
  logic             retry_due;
  logic             any_fault;
  logic             run_fall;
  logic             pg_off_now;
  logic             in_window;

  always_comb begin
    next_s = s;

    next_s.m     = meas_in;
    next_s.run_q = s.m.run;
    run_fall     = s.run_q && !s.m.run;

    pg_hi = s.thr[THR_UPPER_BIT] ? PG_HI_NAR : PG_HI_WIDE;
    pg_lo = s.thr[THR_LOWER_BIT] ? PG_LO_NAR : PG_LO_WIDE;

    // compare vout*100 against setpoint*pct, so no divider is needed
    v100     = cfs_scale(s.m.vout, PCT_BASE);
    above_pb = s.m.vout > s.m.prebias;
    trk_diff = (s.m.vout >= s.m.target) ? (s.m.vout - s.m.target)
                                        : (s.m.target - s.m.vout);

    cond[HF_OV] = s.m.run && above_pb &&
                  (v100 > cfs_scale(s.m.setp, cfs_ov_pct(s.thr[THR_HIGH_LSB +: 2])));
    cond[HF_UV] = s.m.steady && !s.m.oc_hit &&
                  (v100 < cfs_scale(s.m.setp, cfs_uv_pct(s.thr[THR_LOW_LSB +: 2])));
    cond[HF_OC] = s.m.run && above_pb && s.m.oc_hit;
    cond[HF_OT] = s.m.temp > TEMP_TRIP;
    // ramp tracking, enable bit, not during margining
    cond[HF_TR] = s.policy[POL_TRACK_EN] && s.m.ramp_up && !s.m.margin &&
                  (trk_diff > TRACK_TOL_MV);

    // millisecond tick shared by retry and release delay
    tick = s.ms_cnt == 16'(CYC_PER_MS - 1);
    next_s.ms_cnt = tick ? 16'h0000 : s.ms_cnt + 16'h0001;

    // retry period runs while any fault holds
    any_fault = ~&s.flags[HF_TR:HF_OV];
    retry_due = tick && (s.retry_ms == RETRY_MS - 8'd1);
    if (!any_fault) begin
      next_s.retry_ms   = 8'h00;
      next_s.retry_seen = 1'b0;
    end else if (tick) begin
      next_s.retry_ms = retry_due ? 8'h00 : s.retry_ms + 8'h01;
      if (retry_due) begin
        next_s.retry_seen = 1'b1;
      end
    end

    hclr = (reg_wr && reg_addr == OFS_HEALTH) ? reg_wdata[NFLT-1:0] : '0;

    for (int i = 0; i < NFLT; i++) begin
      if (!s.policy[POL_LATCH_BASE + i]) begin
        rel[i] = retry_due && !cond[i];
        if (i == HF_OT) begin
          rel[i] = s.m.temp < TEMP_RESTART;
        end
      end else begin
        // latching: host clear after a retry period, or a run recycle
        rel[i] = !cond[i] && (run_fall || (hclr[i] && s.retry_seen));
      end
      // a trip in the clearing cycle wins
      if (cond[i]) begin
        next_s.flags[i] = 1'b0;
      end else if (!s.flags[i] && rel[i]) begin
        next_s.flags[i] = 1'b1;
      end
    end

    if (s.m.temp > TEMP_WARN_SET) begin
      next_s.flags[HF_PT] = 1'b0;
    end else if (s.m.temp < TEMP_WARN_CLR) begin
      next_s.flags[HF_PT] = 1'b1;
    end

    pg_off_now = s.sdmode[SD_PG_IMMED] ? !s.m.run : s.m.ramp_dn;
    dly_ms     = (s.pgdly > PG_DELAY_MAX_MS) ? PG_DELAY_MAX_MS : s.pgdly;
    // arm at steady state
    // in ramp-down mode a dropped run alone must not pull the pin, so only the drop event disarms
    if (pg_off_now) begin
      next_s.pg_armed = 1'b0;
      next_s.pg_ms    = 8'h00;
    end else if (s.m.run && s.m.steady) begin
      next_s.pg_armed = 1'b1;
    end
    if (s.pg_armed && !pg_off_now && tick && s.pg_ms < dly_ms) begin
      next_s.pg_ms = s.pg_ms + 8'h01;
    end
    in_window = (v100 <= cfs_scale(s.m.setp, pg_hi)) &&
                (v100 >= cfs_scale(s.m.setp, pg_lo));
    // pull the pin low outside the window
    next_s.pg_low = !(s.pg_armed && s.pg_ms >= dly_ms && in_window && !pg_off_now);
    // a pin held low from outside also reads as a warning
    next_s.flags[HF_PG] = !s.pg_low && s.m.pg_in;

    next_s.shut.fast_off   = !next_s.flags[HF_OC] || !next_s.flags[HF_TR];
    next_s.shut.ov_clamp   = !next_s.flags[HF_OV];
    next_s.shut.crit_off   = (!next_s.flags[HF_UV] && s.sdmode[SD_UV_CRIT]) ||
                             (!next_s.flags[HF_OT] && s.sdmode[SD_OT_CRIT]);
    next_s.shut.seq_off    = (!next_s.flags[HF_UV] && !s.sdmode[SD_UV_CRIT]) ||
                             (!next_s.flags[HF_OT] && !s.sdmode[SD_OT_CRIT]);
    // warning bits take no part in shutdown
    next_s.shut.restart_ok = &next_s.flags[HF_TR:HF_OV];

    if (reg_wr) begin
      unique case (reg_addr)
        OFS_POLICY: next_s.policy = reg_wdata;
        OFS_THRESH: begin
          if (!s.m.run) begin
            next_s.thr = reg_wdata[5:0];
          end
        end
        OFS_CURLIM: next_s.curlim = reg_wdata;
        OFS_PGDLY:  next_s.pgdly  = reg_wdata;
        OFS_SDMODE: next_s.sdmode = reg_wdata[2:0];
        default: ;
      endcase
    end

    unique case (reg_addr)
      OFS_POLICY: next_s.rd_data = s.policy;
      OFS_THRESH: next_s.rd_data = {2'b00, s.thr};
      OFS_CURLIM: next_s.rd_data = s.curlim;
      OFS_PGDLY:  next_s.rd_data = s.pgdly;
      OFS_SDMODE: next_s.rd_data = {5'h00, s.sdmode};
      OFS_HEALTH: next_s.rd_data = {1'b0, s.flags};
      default:    next_s.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s            <= '0;
      s.policy     <= POLICY_RST;
      s.thr        <= THRESH_RST;
      s.curlim     <= CURLIM_RST;
      s.pgdly      <= PGDLY_RST;
      s.sdmode     <= SDMODE_RST;
      s.flags      <= HEALTH_RST;
      s.pg_low     <= 1'b1;
      s.shut       <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rd_data  = s.rd_data;
  assign shut         = s.shut;
  assign pg_out       = 1'b0;
  assign pg_oe        = s.pg_low;
  assign oc_tcomp_en  = s.curlim[CURLIM_TCOMP];
  assign health_flags = s.flags;

endmodule : cfs_top

// *** cfs_top_assertions.sv ***
// port-level assertions for the converter fault supervisor
module cfs_top_assertions
  import cfs_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DFLT
) (
  input wire logic       clk,          // clock
  input wire logic       sys_rst,      // reset
  input wire cfs_meas_t  meas_in,      // sensing levels
  input wire logic       reg_wr,       // write strobe
  input wire logic [7:0] reg_addr,     // address
  input wire logic [7:0] reg_wdata,    // write data
  input wire logic [7:0] reg_rd_data,  // read data
  input wire cfs_shut_t  shut,         // shutdown requests
  input wire logic       pg_out,       // pin level
  input wire logic       pg_oe,        // pin enable
  input wire logic       oc_tcomp_en,  // compensation enable
  input wire logic [6:0] health_flags  // status flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic hot;
  logic cur_hit;
  logic volt_hi;
  assign hot     = meas_in.temp > TEMP_TRIP;
  assign cur_hit = meas_in.run && meas_in.oc_hit && meas_in.vout > meas_in.prebias;
  // worst-case 130 percent level, so the trip is due whatever the setting
  assign volt_hi = meas_in.run && meas_in.vout > meas_in.prebias
                   && 32'(meas_in.vout) * 100 > 32'(meas_in.setp) * 130;

  current_trip_a: assert property (cur_hit |-> ##2 !health_flags[HF_OC] && shut.fast_off)
    else $error("overcurrent not tripped");
  heat_trip_a: assert property (hot |-> ##2 !health_flags[HF_OT] && !shut.restart_ok)
    else $error("overtemperature not tripped");
  warn_set_a: assert property (hot |-> ##2 !health_flags[HF_PT])
    else $error("temperature warning not set");
  warn_clear_a: assert property (meas_in.temp < TEMP_WARN_CLR |-> ##2 health_flags[HF_PT])
    else $error("temperature warning not cleared");
  volt_clamp_a: assert property (volt_hi |-> ##2 shut.ov_clamp && !health_flags[HF_OV])
    else $error("overvoltage clamp missing");
  pin_pull_a: assert property (!meas_in.pg_in |-> ##2 !health_flags[HF_PG])
    else $error("low pin not flagged");
  spare_bits_a: assert property ($past(reg_addr) == OFS_THRESH |-> reg_rd_data[7:6] == 2'h0)
    else $error("spare threshold bits not zero");
  thr_locked_a: assert property (reg_wr && reg_addr == OFS_THRESH && $past(meas_in.run)
    ##1 !reg_wr && reg_addr == OFS_THRESH |-> ##1 $stable(reg_rd_data))
    else $error("threshold written while running");
  tcomp_follow_a: assert property (reg_wr && reg_addr == OFS_CURLIM ##1
    !(reg_wr && reg_addr == OFS_CURLIM) |-> ##1 oc_tcomp_en == $past(reg_wdata[CURLIM_TCOMP], 2))
    else $error("compensation enable not following");
endmodule : cfs_top_assertions

bind cfs_top cfs_top_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .meas_in(meas_in), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .shut(shut), .pg_out(pg_out),
  .pg_oe(pg_oe), .oc_tcomp_en(oc_tcomp_en), .health_flags(health_flags));

// *** cfs_stage_model.sv ***
// power stage sensing model with the pulled-up window pin
module cfs_stage_model
  import cfs_pkg::*;
(
  input  wire cfs_meas_t cmd,       // levels asked for by the bench
  input  wire logic      ext_pull,  // outside circuit pulling the pin low
  input  wire logic      pg_oe,     // supervisor pull-down enable
  output cfs_meas_t      meas       // levels seen by the supervisor
);
  always_comb begin
    meas = cmd;
    meas.pg_in = !(pg_oe || ext_pull);
  end
endmodule : cfs_stage_model

// *** cfs_top_tb.sv ***
// self-checking bench for the converter fault supervisor
module cfs_top_tb
  import cfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] thr;
    logic [7:0] pct;
    logic [2:0] b;
    logic       low_bad;
  } cfs_probe_t;
  localparam int CPM = 10;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        ext_pull = 1'b0;
  logic [7:0]  reg_rd_data;
  logic        pg_out;
  logic        pg_oe;
  logic        oc_tcomp_en;
  logic [6:0]  health_flags;
  cfs_shut_t   shut;
  cfs_meas_t   cmd;
  cfs_meas_t   base;
  cfs_meas_t   c;
  cfs_meas_t   meas_in;
  int          mismatches = 0;
  int          n_tests = 0;
  logic [7:0]  rd;
  logic [39:0] rst_vals = 40'h00_0080_0843;
  logic [39:0] temps = 40'h6D_6F74_7679;
  cfs_probe_t  tab [12] = '{
    '{8'h08, 8'h4B, 3'h1, 1'h1}, '{8'h09, 8'h50, 3'h1, 1'h1},
    '{8'h0A, 8'h55, 3'h1, 1'h1}, '{8'h0B, 8'h5A, 3'h1, 1'h1},
    '{8'h00, 8'h6E, 3'h0, 1'h0}, '{8'h04, 8'h78, 3'h0, 1'h0},
    '{8'h08, 8'h82, 3'h0, 1'h0}, '{8'h0C, 8'h82, 3'h0, 1'h0},
    '{8'h08, 8'h6E, 3'h6, 1'h0}, '{8'h28, 8'h69, 3'h6, 1'h0},
    '{8'h08, 8'h5A, 3'h6, 1'h1}, '{8'h18, 8'h5F, 3'h6, 1'h1}};

  always #25 clk = ~clk;

  cfs_stage_model u_stage (.cmd(cmd), .ext_pull(ext_pull), .pg_oe(pg_oe), .meas(meas_in));
  cfs_top #(.CYC_PER_MS(CPM)) dut (
    .clk(clk), .sys_rst(sys_rst), .meas_in(meas_in), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .shut(shut), .pg_out(pg_out),
    .pg_oe(pg_oe), .oc_tcomp_en(oc_tcomp_en), .health_flags(health_flags));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 d = reg_rd_data;
  endtask : rdreg

  // idle long enough afterwards for a retry period to release any non-latching fault
  task automatic trial(input cfs_meas_t tc, input int b, input logic exp);
    @(posedge clk);
    #1 cmd = tc;
    repeat (20) @(posedge clk);
    #1 check("flag_bit", {7'h0, health_flags[b]}, {7'h0, exp});
    cmd = base;
    repeat (140 * CPM) @(posedge clk);
  endtask : trial

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial begin
    base = '0;
    base.setp = 12'h3E8;
    base.vout = 12'h3E8;
    base.target = 12'h3E8;
    base.temp = 8'h19;
    cmd = base;
    repeat (8) @(posedge clk);
    check("flags_rst", {1'b0, health_flags}, 8'h7F);
    check("oe_rst", {7'h0, pg_oe}, 8'h01);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rdreg(8'(i), rd);
      check("reg_rst", rd, rst_vals[8*i+:8]);
    end
    wr(8'h10, 8'h5A);
    rdreg(8'h10, rd);
    check("unmapped", rd, 8'h00);
    wr(OFS_THRESH, 8'hFF);
    rdreg(OFS_THRESH, rd);
    check("thr_spare", rd, 8'h3F);
    cmd.run = 1'b1;
    repeat (3) @(posedge clk);
    wr(OFS_THRESH, 8'h00);
    rdreg(OFS_THRESH, rd);
    check("thr_locked", rd, 8'h3F);
    cmd = base;
    repeat (3) @(posedge clk);
    foreach (tab[i]) begin
      // thresholds written only with run low
      wr(OFS_THRESH, tab[i].thr);
      rdreg(OFS_THRESH, rd);
      check("thr_rd", rd, tab[i].thr);
      for (int k = 0; k < 2; k++) begin
        c = base;
        c.run = 1'b1;
        c.steady = 1'b1;
        c.setp = (i % 2) ? 12'h7D0 : 12'h3E8;
        c.vout = 12'((32'(c.setp) * tab[i].pct) / 100 + 2 * k - 1);
        trial(c, tab[i].b, !(tab[i].low_bad ^ k[0]));
      end
    end
    c = base;
    c.run = 1'b1;
    c.steady = 1'b1;
    @(posedge clk);
    #1 cmd = c;
    ext_pull = 1'b1;
    repeat (20) @(posedge clk);
    #1 check("pin_pull", {7'h0, health_flags[HF_PG]}, 8'h00);
    check("no_shut", {3'h0, shut}, 8'h01);
    ext_pull = 1'b0;
    repeat (20) @(posedge clk);
    #1 check("pin_free", {7'h0, health_flags[HF_PG]}, 8'h01);
    cmd = base;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1 cmd.temp = temps[8*i+:8];
      repeat (140 * CPM) @(posedge clk);
      #1 check("warn", {7'h0, health_flags[HF_PT]}, {7'h0, i > 1});
      check("heat", {7'h0, health_flags[HF_OT]}, {7'h0, i > 3});
    end
    c = base;
    c.run = 1'b1;
    c.oc_hit = 1'b1;
    trial(c, HF_OC, 1'b0);
    c.prebias = 12'h44C;
    trial(c, HF_OC, 1'b1);
    wr(OFS_POLICY, 8'hC3);
    c = base;
    c.run = 1'b1;
    c.ramp_up = 1'b1;
    c.vout = 12'h2BC;
    trial(c, HF_TR, 1'b0);
    c.margin = 1'b1;
    trial(c, HF_TR, 1'b1);
    wr(OFS_POLICY, 8'h43);
    c.margin = 1'b0;
    trial(c, HF_TR, 1'b1);
    wr(OFS_CURLIM, 8'h00);
    @(posedge clk);
    #1 check("tcomp_off", {7'h0, oc_tcomp_en}, 8'h00);
    wr(OFS_CURLIM, 8'h80);
    @(posedge clk);
    #1 check("tcomp_on", {7'h0, oc_tcomp_en}, 8'h01);
    wr(OFS_PGDLY, 8'h02);
    wr(OFS_SDMODE, 8'h04);
    c = base;
    c.run = 1'b1;
    c.steady = 1'b1;
    @(posedge clk);
    #1 cmd = c;
    repeat (5) @(posedge clk);
    #1 check("pg_hold", {7'h0, pg_oe}, 8'h01);
    repeat (40) @(posedge clk);
    #1 check("pg_release", {7'h0, pg_oe}, 8'h00);
    check("pg_drive", {7'h0, pg_out}, 8'h00);
    cmd.run = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("pg_drop_cmd", {7'h0, pg_oe}, 8'h01);
    wr(OFS_SDMODE, 8'h00);
    cmd.run = 1'b1;
    repeat (40) @(posedge clk);
    #1 check("pg_up_again", {7'h0, pg_oe}, 8'h00);
    cmd.run = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("pg_wait_ramp", {7'h0, pg_oe}, 8'h00);
    cmd.ramp_dn = 1'b1;
    repeat (3) @(posedge clk);
    #1 check("pg_drop_ramp", {7'h0, pg_oe}, 8'h01);
    c = base;
    c.run = 1'b1;
    c.vout = 12'h578;
    cmd = c;
    repeat (20) @(posedge clk);
    #1 check("ov_shut", {3'h0, shut}, 8'h08);
    cmd.vout = base.vout;
    wr(OFS_HEALTH, 8'h01);
    repeat (3) @(posedge clk);
    #1 check("ov_early_clr", {7'h0, health_flags[HF_OV]}, 8'h00);
    repeat (140 * CPM) @(posedge clk);
    wr(OFS_HEALTH, 8'h01);
    repeat (3) @(posedge clk);
    #1 check("ov_host_clr", {7'h0, health_flags[HF_OV]}, 8'h01);
    wr(OFS_SDMODE, 8'h01);
    c.vout = 12'h2BC;
    c.steady = 1'b1;
    cmd = c;
    repeat (20) @(posedge clk);
    #1 check("uv_crit", {3'h0, shut}, 8'h02);
    final_report();
  end
endmodule : cfs_top_tb
